// [otp_sfdp_regs.svh]
`ifndef OTP_SFDP_REGS_SVH
`define OTP_SFDP_REGS_SVH

// ==========================================================================
// Opcodes
// ==========================================================================
`define OP_TABLE_READ     8'h5A
`define OP_SECURITY_WRITE 8'h2F

// ==========================================================================
// Command framing
// ==========================================================================
`define ADDR_BYTES_LAST   2'h2
`define BIT_LAST          3'h7
`define BIT_FIRST         3'h0

// ==========================================================================
// Security register layout
// ==========================================================================
`define SEC_FACTORY_BIT   0
`define SEC_LOCKDOWN_BIT  1
`define SEC_RESERVED_VAL  6'h00
`define SEC_RESET_VAL     8'h00

// ==========================================================================
// Discovery table addresses
// ==========================================================================
`define TA_SIG0           8'h00
`define TA_SIG1           8'h01
`define TA_SIG2           8'h02
`define TA_SIG3           8'h03
`define TA_MINOR          8'h04
`define TA_MAJOR          8'h05
`define TA_NUM_HDR        8'h06
`define TA_H0_ID          8'h08
`define TA_H0_MINOR       8'h09
`define TA_H0_MAJOR       8'h0A
`define TA_H0_LEN         8'h0B
`define TA_H0_PTR0        8'h0C
`define TA_H0_PTR1        8'h0D
`define TA_H0_PTR2        8'h0E
`define TA_H1_ID          8'h10
`define TA_H1_MINOR       8'h11
`define TA_H1_MAJOR       8'h12
`define TA_H1_LEN         8'h13
`define TA_H1_PTR0        8'h14
`define TA_H1_PTR1        8'h15
`define TA_H1_PTR2        8'h16
`define TA_STD_B0         8'h30
`define TA_STD_B1         8'h31
`define TA_STD_B2         8'h32

// ==========================================================================
// Discovery table contents
// ==========================================================================
`define TV_SIG0           8'h53
`define TV_SIG1           8'h46
`define TV_SIG2           8'h44
`define TV_SIG3           8'h50
`define TV_REV_MINOR      8'h00
`define TV_REV_MAJOR      8'h01
`define TV_NUM_HDR        8'h01
`define TV_STD_ID         8'h00
`define TV_STD_LEN        8'h09
`define TV_VND_LEN        8'h04
`define TV_STD_PTR        8'h30
`define TV_VND_PTR        8'h60
`define TV_PTR_HIGH       8'h00
`define TV_UNUSED         8'hFF
`define TV_ERASE_4K       2'h1
`define TV_GRAN_64        1'h1
`define TV_VOL_STATUS     2'h0
`define TV_FIXED_ONES     3'h7
`define TV_ERASE_OPCODE   8'h20
`define TV_DUAL_OUT       1'h1
`define TV_ADDR_3BYTE     2'h0
`define TV_NO_OTHER_READS 4'h0
`define TV_B2_UNUSED      1'h1

`endif

// [otp_sfdp_pkg.sv]
package otp_sfdp_pkg;

   typedef enum logic [5:0] {
      st_idle   = 6'h01,
      st_opcode = 6'h02,
      st_addr   = 6'h04,
      st_dummy  = 6'h08,
      st_data   = 6'h10,
      st_ignore = 6'h20
   } state_type;

endpackage

// [pin_sync.sv]
// ==========================================================================
// Three-stage pin synchroniser with agreement filter
// ==========================================================================
module pin_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic pin,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic level_ff;
   logic nxt_level;
   logic agree;

   // The first stage feeds only the second; the change is accepted when stages two and three agree.
   always_comb begin
      agree     = (s2_ff == s3_ff);
      nxt_level = agree ? s3_ff : level_ff;
      rise      = agree && s3_ff && !level_ff;
      fall      = agree && !s3_ff && level_ff;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_ff    <= RESET_VAL;
         s2_ff    <= RESET_VAL;
         s3_ff    <= RESET_VAL;
         level_ff <= RESET_VAL;
      end else begin
         s1_ff    <= pin;
         s2_ff    <= s1_ff;
         s3_ff    <= s2_ff;
         level_ff <= nxt_level;
      end
   end

   assign level = level_ff;

endmodule

// [otp_sfdp_main.sv]
// Notes on behaviour
// - Security register write needs no prior write-latch-set command.
// - Security register write changes only the lockdown bit, bit 1.
// - Once lockdown bit is 1, all further OTP area updates are refused.
// - Security write executes only if chip select rises right after the eighth opcode bit, with no further clocks.
// - Table read: opcode 5Ah, three address bytes, one dummy byte, then data.
// - Chip select rising during data out stops output drive at once.
// - Bytes 04h and 05h return revision 00h and 01h.
// - Byte 06h returns 01h, meaning two parameter headers.
// - First header: ID 00h at 08h, revision 1.0 at 09h and 0Ah.
// - Length bytes: 09h at 0Bh, 04h at 13h, in 32-bit words.
// - Bytes 0Ch-0Eh hold standard table pointer 30h, 00h, 00h.
// - Second header: vendor code at 10h, pointer 60h,00h,00h at 14h-16h.
// - Byte 30h returns E5h (uniform 4KB erase); byte 31h returns 20h.
// - Bit 2 of byte 30h reads 1: write granularity 64 bytes or more.
// - Bits 3 and 4 of byte 30h read 0: nonvolatile status bits.
// - Bits 7:5 of byte 30h always read 111b.
// - Bit 16 of first standard word reads 1: dual output fast read.
// - Bits 18:17 of first standard word read 00b: three-byte addressing.
// - Ignore security write during OTP access; after lockdown only reads.
// - Security bit 0 reports factory lock state.
`include "otp_sfdp_regs.svh"

module otp_sfdp_main #(
   parameter logic [7:0] VENDOR_CODE     = 8'h5D, // Arbitrary vendor code value.
   parameter logic [7:0] SEC_WRITE_OP    = `OP_SECURITY_WRITE
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       cs_b,
   input  wire logic       sclk,
   input  wire logic       si,
   input  wire logic       factory_lock,
   input  wire logic       otp_access,
   output logic            so,
   output logic            so_oe_b,
   output logic [7:0]      security_reg,
   output logic            otp_update_allow,
   output logic            read_only_mode,
   output logic            sec_write_reject
);

   // ========================================================================
   // Table contents
   // ========================================================================
   function automatic logic [7:0] table_byte(input logic [23:0] a);
      logic [7:0] v;
      v = `TV_UNUSED;
      // Everything above the first page of the table is unused.
      if (a[23:8] == 16'h0000) begin
         unique case (a[7:0])
            `TA_SIG0:     v = `TV_SIG0;
            `TA_SIG1:     v = `TV_SIG1;
            `TA_SIG2:     v = `TV_SIG2;
            `TA_SIG3:     v = `TV_SIG3;
            `TA_MINOR:    v = `TV_REV_MINOR;
            `TA_MAJOR:    v = `TV_REV_MAJOR;
            `TA_NUM_HDR:  v = `TV_NUM_HDR;
            `TA_H0_ID:    v = `TV_STD_ID;
            `TA_H0_MINOR: v = `TV_REV_MINOR;
            `TA_H0_MAJOR: v = `TV_REV_MAJOR;
            `TA_H0_LEN:   v = `TV_STD_LEN;
            `TA_H0_PTR0:  v = `TV_STD_PTR;
            `TA_H0_PTR1:  v = `TV_PTR_HIGH;
            `TA_H0_PTR2:  v = `TV_PTR_HIGH;
            `TA_H1_ID:    v = VENDOR_CODE;
            `TA_H1_MINOR: v = `TV_REV_MINOR;
            `TA_H1_MAJOR: v = `TV_REV_MAJOR;
            `TA_H1_LEN:   v = `TV_VND_LEN;
            `TA_H1_PTR0:  v = `TV_VND_PTR;
            `TA_H1_PTR1:  v = `TV_PTR_HIGH;
            `TA_H1_PTR2:  v = `TV_PTR_HIGH;
            // Fixed ones, volatile-status bits, granularity, erase size.
            `TA_STD_B0:   v = {`TV_FIXED_ONES, `TV_VOL_STATUS, `TV_GRAN_64, `TV_ERASE_4K};
            `TA_STD_B1:   v = `TV_ERASE_OPCODE;
            `TA_STD_B2:   v = {`TV_B2_UNUSED, `TV_NO_OTHER_READS, `TV_ADDR_3BYTE, `TV_DUAL_OUT};
            default:      v = `TV_UNUSED;
         endcase
      end
      return v;
   endfunction

   // ========================================================================
   // Pin synchronisers
   // ========================================================================
   // Each pin passes three flops, so its edges are seen three to four clocks late;
   // every link clock phase must therefore last at least four clocks.
   logic cs_lvl;
   logic cs_rise;
   logic cs_fall;
   logic sclk_rise;
   logic sclk_fall;
   logic si_lvl;
   logic fl_lvl;

   pin_sync #(.RESET_VAL(1'b1)) u_cs (
      .clk   (clk),
      .rst_b (rst_b),
      .pin   (cs_b),
      .level (cs_lvl),
      .rise  (cs_rise),
      .fall  (cs_fall)
   );

   pin_sync #(.RESET_VAL(1'b0)) u_sclk (
      .clk   (clk),
      .rst_b (rst_b),
      .pin   (sclk),
      .level (),
      .rise  (sclk_rise),
      .fall  (sclk_fall)
   );

   pin_sync #(.RESET_VAL(1'b0)) u_si (
      .clk   (clk),
      .rst_b (rst_b),
      .pin   (si),
      .level (si_lvl),
      .rise  (),
      .fall  ()
   );

   pin_sync #(.RESET_VAL(1'b0)) u_fl (
      .clk   (clk),
      .rst_b (rst_b),
      .pin   (factory_lock),
      .level (fl_lvl),
      .rise  (),
      .fall  ()
   );

   // ========================================================================
   // Command state
   // ========================================================================
   otp_sfdp_pkg::state_type state_ff;
   otp_sfdp_pkg::state_type nxt_state;
   logic [2:0]  bit_cnt_ff;
   logic [2:0]  nxt_bit_cnt;
   logic [1:0]  byte_cnt_ff;
   logic [1:0]  nxt_byte_cnt;
   logic [7:0]  in_ff;
   logic [7:0]  nxt_in;
   logic [23:0] addr_ff;
   logic [23:0] nxt_addr;
   logic [7:0]  out_ff;
   logic [7:0]  nxt_out;
   logic [2:0]  out_cnt_ff;
   logic [2:0]  nxt_out_cnt;
   logic        armed_ff;
   logic        nxt_armed;
   logic        lock_ff;
   logic        nxt_lock;
   logic        fact_ff;
   logic        nxt_fact;
   logic        so_ff;
   logic        nxt_so;
   logic        oe_b_ff;
   logic        nxt_oe_b;
   logic        reject_ff;
   logic        nxt_reject;
   logic        allow_ff;
   logic        nxt_allow;
   logic [7:0]  shift_in;

   // Unknown opcodes park in the ignore state until select rises, so later bits
   // of the same frame can never be mistaken for a new command.
   always_comb begin
      nxt_state    = state_ff;
      nxt_bit_cnt  = bit_cnt_ff;
      nxt_byte_cnt = byte_cnt_ff;
      nxt_in       = in_ff;
      nxt_addr     = addr_ff;
      nxt_out      = out_ff;
      nxt_out_cnt  = out_cnt_ff;
      nxt_armed    = armed_ff;
      nxt_lock     = lock_ff;
      nxt_so       = so_ff;
      nxt_oe_b     = oe_b_ff;
      nxt_reject   = 1'b0;
      nxt_fact     = fl_lvl;
      shift_in     = {in_ff[6:0], si_lvl};
      if (cs_fall) begin
         // A new select always starts a fresh command with the output released.
         nxt_state   = otp_sfdp_pkg::st_opcode;
         nxt_bit_cnt = `BIT_FIRST;
         nxt_armed   = 1'b0;
         nxt_oe_b    = 1'b1;
      end else if (cs_rise) begin
         nxt_state = otp_sfdp_pkg::st_idle;
         nxt_oe_b  = 1'b1;
         nxt_armed = 1'b0;
         // A stray clock after the opcode clears the arm, so a late select rise is refused.
         if (armed_ff && bit_cnt_ff == `BIT_FIRST) begin
            if (otp_access) begin
               nxt_reject = 1'b1;
            end else begin
               nxt_lock = 1'b1;
            end
         end
      end else if (!cs_lvl && sclk_rise && state_ff != otp_sfdp_pkg::st_idle) begin
         nxt_in      = shift_in;
         nxt_bit_cnt = bit_cnt_ff + 3'h1;
         nxt_armed   = 1'b0;
         if (bit_cnt_ff == `BIT_LAST) begin
            unique case (state_ff)
               otp_sfdp_pkg::st_opcode: begin
                  if (shift_in == `OP_TABLE_READ) begin
                     nxt_state    = otp_sfdp_pkg::st_addr;
                     nxt_byte_cnt = 2'h0;
                  end else begin
                     nxt_state = otp_sfdp_pkg::st_ignore;
                     // Once locked, a repeat write has nothing left to change.
                     nxt_armed = (shift_in == SEC_WRITE_OP) && !lock_ff;
                  end
               end
               otp_sfdp_pkg::st_addr: begin
                  // Address bytes arrive high byte first and shift up.
                  nxt_addr     = {addr_ff[15:0], shift_in};
                  nxt_byte_cnt = byte_cnt_ff + 2'h1;
                  if (byte_cnt_ff == `ADDR_BYTES_LAST) begin
                     nxt_state = otp_sfdp_pkg::st_dummy;
                  end
               end
               otp_sfdp_pkg::st_dummy: begin
                  nxt_state   = otp_sfdp_pkg::st_data;
                  nxt_out     = table_byte(addr_ff);
                  nxt_out_cnt = `BIT_FIRST;
               end
               otp_sfdp_pkg::st_data: begin
                  nxt_state = otp_sfdp_pkg::st_data;
               end
               otp_sfdp_pkg::st_ignore: begin
                  nxt_state = otp_sfdp_pkg::st_ignore;
               end
               otp_sfdp_pkg::st_idle: begin
                  nxt_state = otp_sfdp_pkg::st_idle;
               end
            endcase
         end
      end else if (!cs_lvl && sclk_fall && state_ff == otp_sfdp_pkg::st_data) begin
         // Data leaves on the falling edge so the host can sample on the rising one.
         nxt_so      = out_ff[7];
         nxt_oe_b    = 1'b0;
         // Ones fill from the right and never reach the pin before the next reload.
         nxt_out     = {out_ff[6:0], 1'b1};
         nxt_out_cnt = out_cnt_ff + 3'h1;
         if (out_cnt_ff == `BIT_LAST) begin
            nxt_addr = addr_ff + 24'h000001;
            nxt_out  = table_byte(addr_ff + 24'h000001);
         end
      end
      // Lockdown never clears, so this copy tracks it exactly and keeps the output flop-driven.
      nxt_allow = !nxt_lock;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff    <= otp_sfdp_pkg::st_idle;
         bit_cnt_ff  <= `BIT_FIRST;
         byte_cnt_ff <= 2'h0;
         in_ff       <= 8'h00;
         addr_ff     <= 24'h000000;
         out_ff      <= 8'hFF;
         out_cnt_ff  <= `BIT_FIRST;
         armed_ff    <= 1'b0;
         lock_ff     <= 1'b0;
         fact_ff     <= 1'b0;
         so_ff       <= 1'b0;
         oe_b_ff     <= 1'b1;
         reject_ff   <= 1'b0;
         allow_ff    <= 1'b1;
      end else begin
         state_ff    <= nxt_state;
         bit_cnt_ff  <= nxt_bit_cnt;
         byte_cnt_ff <= nxt_byte_cnt;
         in_ff       <= nxt_in;
         addr_ff     <= nxt_addr;
         out_ff      <= nxt_out;
         out_cnt_ff  <= nxt_out_cnt;
         armed_ff    <= nxt_armed;
         lock_ff     <= nxt_lock;
         fact_ff     <= nxt_fact;
         so_ff       <= nxt_so;
         oe_b_ff     <= nxt_oe_b;
         reject_ff   <= nxt_reject;
         allow_ff    <= nxt_allow;
      end
   end

   // ========================================================================
   // Outputs
   // ========================================================================
   // The lockdown bit is held here only; a real part would back it with nonvolatile storage.
   assign so               = so_ff;
   assign so_oe_b          = oe_b_ff;
   // Bits 7:2 are reserved and always read as zero.
   assign security_reg     = {`SEC_RESERVED_VAL, lock_ff, fact_ff};
   assign otp_update_allow = allow_ff;
   assign read_only_mode   = lock_ff;
   assign sec_write_reject = reject_ff;

endmodule

// [otp_sfdp_main_monitor.sv]
// ==========================================================================
// Port checker
// ==========================================================================
module otp_sfdp_main_monitor (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       cs_b,
   input wire logic       sclk,
   input wire logic       si,
   input wire logic       factory_lock,
   input wire logic       otp_access,
   input wire logic       so,
   input wire logic       so_oe_b,
   input wire logic [7:0] security_reg,
   input wire logic       otp_update_allow,
   input wire logic       read_only_mode,
   input wire logic       sec_write_reject
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_lock_sticky: assert property (security_reg[1] |=> security_reg[1]) else $error("lockdown bit cleared");
   a_allow_tie: assert property (otp_update_allow != security_reg[1]) else $error("update allow wrong");
   a_ro_tie: assert property (read_only_mode == security_reg[1]) else $error("read only mode wrong");
   a_reserved_zero: assert property (security_reg[7:2] == 6'h00) else $error("reserved bits set");
   a_lock_at_cs: assert property ($rose(security_reg[1]) |-> cs_b && !otp_access)
      else $error("lockdown set at wrong time");
   a_reject_pulse: assert property (sec_write_reject |=> !sec_write_reject) else $error("reject too long");
   a_reject_no_lock: assert property (sec_write_reject |-> cs_b ##1 !$rose(security_reg[1]))
      else $error("lockdown set on reject");
   a_oe_release: assert property ($rose(cs_b) |-> ##[1:7] so_oe_b) else $error("output not released");
   a_oe_idle: assert property (cs_b [*8] |-> so_oe_b) else $error("output driven while idle");
   a_factory_set: assert property (factory_lock [*8] |-> security_reg[0]) else $error("factory bit low");
   a_factory_clr: assert property (!factory_lock [*8] |-> !security_reg[0]) else $error("factory bit high");
endmodule

bind otp_sfdp_main otp_sfdp_main_monitor otp_sfdp_main_monitor_inst (
   .clk              (clk),
   .rst_b            (rst_b),
   .cs_b             (cs_b),
   .sclk             (sclk),
   .si               (si),
   .factory_lock     (factory_lock),
   .otp_access       (otp_access),
   .so               (so),
   .so_oe_b          (so_oe_b),
   .security_reg     (security_reg),
   .otp_update_allow (otp_update_allow),
   .read_only_mode   (read_only_mode),
   .sec_write_reject (sec_write_reject)
);

// [spi_host_model.sv]
// ==========================================================================
// Host controller model, mode 0
// ==========================================================================
module spi_host_model (
   input  wire logic clk,
   output logic      cs_b,
   output logic      sclk,
   output logic      si,
   input  wire logic so,
   input  wire logic so_oe_b
);
   timeunit 1ns;
   timeprecision 1ns;
   logic oe_lost;

   initial begin
      cs_b = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
      oe_lost = 1'b0;
   end

   task automatic frame_start();
      @(posedge clk);
      cs_b <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // Data is sampled late in the high phase, so a slow device still counts.
   task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         @(posedge clk);
         sclk <= 1'b0;
         si <= tx[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         #1;
         // A released line shows the inverse of the last bit, so an undriven read cannot pass.
         rx[i] = (so_oe_b === 1'b0) ? so : ~so;
         if (so_oe_b !== 1'b0) oe_lost = 1'b1;
      end
   endtask

   // The clock stands low between frames and the data line no longer holds its value.
   task automatic frame_end();
      @(posedge clk);
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
      cs_b <= 1'b1;
      si <= ~si;
      repeat (8) @(posedge clk);
   endtask
endmodule

// [otp_sfdp_main_tb_top.sv]
module otp_sfdp_main_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] VCODE = 8'h3C; // Arbitrary vendor code.
   logic       clk, rst_b, cs_b, sclk, si, so, so_oe_b, factory_lock, otp_access;
   logic       otp_update_allow, read_only_mode, sec_write_reject, rej_seen;
   logic [7:0] security_reg;
   int         n_fail, n_tests;

   initial clk = 1'b0;
   always #25 clk = ~clk;
   always @(posedge clk) begin
      if (!rst_b) rej_seen <= 1'b0;
      else if (sec_write_reject === 1'b1) rej_seen <= 1'b1;
   end

   otp_sfdp_main #(.VENDOR_CODE(VCODE)) otp_sfdp_main_inst (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk),
      .si(si), .factory_lock(factory_lock), .otp_access(otp_access), .so(so), .so_oe_b(so_oe_b),
      .security_reg(security_reg), .otp_update_allow(otp_update_allow), .read_only_mode(read_only_mode),
      .sec_write_reject(sec_write_reject));
   spi_host_model spi_host_model_inst (.clk(clk), .cs_b(cs_b), .sclk(sclk), .si(si), .so(so), .so_oe_b(so_oe_b));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] exp_byte(input logic [23:0] a);
      case (a)
         24'h00: return 8'h53;
         24'h01: return 8'h46;
         24'h02: return 8'h44;
         24'h03: return 8'h50;
         24'h04: return 8'h00;
         24'h05, 24'h06: return 8'h01;
         24'h08, 24'h09: return 8'h00;
         24'h0A, 24'h12: return 8'h01;
         24'h0B: return 8'h09;
         24'h13: return 8'h04;
         24'h0C: return 8'h30;
         24'h0D, 24'h0E, 24'h11, 24'h15, 24'h16: return 8'h00;
         24'h10: return VCODE;
         24'h14: return 8'h60;
         24'h30: return 8'hE5;
         24'h31: return 8'h20;
         24'h32: return 8'h81;
         default: return 8'hFF;
      endcase
   endfunction

   // ==========================================================================
   // Bus operations
   // ==========================================================================
   // Every read ends inside a byte to show that output stops at any moment.
   task automatic read_table(input logic [23:0] addr, input int n);
      logic [7:0] rx;
      spi_host_model_inst.frame_start();
      spi_host_model_inst.shift(8'h5A, 8, rx);
      for (int i = 2; i >= 0; i--) spi_host_model_inst.shift(addr[8*i +: 8], 8, rx);
      spi_host_model_inst.shift(8'hA5, 8, rx);
      spi_host_model_inst.oe_lost = 1'b0;
      for (int i = 0; i < n; i++) begin
         spi_host_model_inst.shift(8'h00, 8, rx);
         check(rx, exp_byte(addr + 24'(i)));
      end
      spi_host_model_inst.shift(8'h00, 3, rx);
      check({7'h00, spi_host_model_inst.oe_lost}, 8'h00);
      spi_host_model_inst.frame_end();
      check({7'h00, so_oe_b}, 8'h01);
   endtask

   task automatic sec_write(input int extra, input logic acc);
      logic [7:0] rx;
      @(posedge clk);
      otp_access <= acc;
      spi_host_model_inst.frame_start();
      spi_host_model_inst.shift(8'h2F, 8, rx);
      if (extra > 0) spi_host_model_inst.shift(8'h00, extra, rx);
      spi_host_model_inst.frame_end();
      otp_access <= 1'b0;
   endtask

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic t_reset();
      check(security_reg, 8'h00);
      check({5'h00, otp_update_allow, read_only_mode, so_oe_b}, 8'h05);
      factory_lock <= 1'b1;
      repeat (10) @(posedge clk);
      check(security_reg, 8'h01);
      factory_lock <= 1'b0;
      repeat (10) @(posedge clk);
      check(security_reg, 8'h00);
   endtask

   task automatic t_table();
      read_table(24'h000000, 24);
      read_table(24'h000030, 4);
      read_table(24'h0000FF, 2);
   endtask

   task automatic t_refused();
      sec_write(3, 1'b0);
      check(security_reg, 8'h00);
      sec_write(8, 1'b0);
      check(security_reg, 8'h00);
      check({7'h00, rej_seen}, 8'h00);
      sec_write(0, 1'b1);
      check(security_reg, 8'h00);
      check({7'h00, rej_seen}, 8'h01);
   endtask

   task automatic t_lock();
      sec_write(0, 1'b0);
      check(security_reg, 8'h02);
      check({6'h00, otp_update_allow, read_only_mode}, 8'h01);
      read_table(24'h000004, 3);
   endtask

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      rst_b = 1'b0;
      factory_lock = 1'b0;
      otp_access = 1'b0;
      n_fail = 0;
      n_tests = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      t_reset();
      t_table();
      t_refused();
      t_lock();
      results();
   end

   // The whole run needs about 4500 cycles.
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      results();
   end
endmodule
